/* File: shared/ddrb_pkg.sv */
// Constants, command codes and types for the second DDR channel pin interface.
// Assumes a 100 MHz core clock and a forwarded command clock of one sixteenth of that rate.
// Notes on behaviour
// R1 - Drive six forwarded command clock pairs; memory samples at true-rise, complement-fall crossing.
// R2 - Complement leg of each forwarded clock is always the inverse of its true leg.
// R3 - Three forwarded clock pairs go to each memory module.
// R4 - Four active-low row selects, one per row, change only on forwarded clock rise.
// R5 - Row and column addresses share one 13-bit address bus, time-multiplexed.
// R6 - A 2-bit bank address selects the bank within the selected row.
// R7 - Commands are coded on row strobe, column strobe and write lines, qualified by select.
// R8 - Read and write data share a bidirectional 64-bit data bus.
// R9 - On writes each data strobe transition sits in the centre of its data eye.
// R10 - On reads the memory returns edge-aligned strobes; capture data relative to them.
// R11 - Strobes zero to seven time data bytes in ascending order; strobe eight the check byte.
// R12 - Row clock enables carry out the power-up initialization sequence.
// R13 - Row clock enables move every row into self-refresh on suspend, out on resume.
// R14 - Idle rows are powered down by clock enable and woken before any command; self-refresh entry selects every row without waking powered-down rows.
// R15 - Four row clock enables, one per row, change only on forwarded clock rise.
// R16 - An 8-bit check byte travels at double data rate with its own strobe.
// R17 - Commands use the usual truth table: activate, read, write, precharge, refresh, mode, nop.
package ddrb_pkg;
  localparam int CORE_PERIOD_NS = 10;
  localparam int FWD_PERIOD_NS = 160;
  localparam int HALF_CYC = FWD_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam int QUART_CYC = HALF_CYC / 2;
  localparam int INIT_CKE_LOW_NS = 200000;
  localparam int INIT_CKE_LOW_CYC = (INIT_CKE_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int NUM_ROWS = 4;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DATA_W = 64;
  localparam int CHK_W = 8;
  localparam int LANE_W = 8;
  localparam int LANES = 9;
  localparam int PAIRS_PER_DIMM = 3;
  localparam int DIMMS = 2;
  localparam logic [NUM_ROWS-1:0] CS_IDLE = 4'hF;
  localparam logic [NUM_ROWS-1:0] CKE_RST = 4'h0;
  localparam logic [2:0] RWE_NOP = 3'h7;
  localparam logic [2:0] RWE_ACT = 3'h3;
  localparam logic [2:0] RWE_RD = 3'h5;
  localparam logic [2:0] RWE_WR = 3'h4;
  localparam logic [2:0] RWE_PRE = 3'h2;
  localparam logic [2:0] RWE_REF = 3'h1;
  localparam logic [2:0] RWE_MRS = 3'h0;

  typedef enum logic [2:0] {DDRB_NOP, DDRB_ACT, DDRB_RD, DDRB_WR, DDRB_PRE, DDRB_REF, DDRB_MRS} ddrb_cmd_t;
  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SREF} ddrb_state_t;

  // Maps a user command onto the row strobe, column strobe and write lines.
  function automatic logic [2:0] ddrb_encode(input ddrb_cmd_t c);
    logic [2:0] r;
    r = RWE_NOP;
    case (c)
      DDRB_ACT: r = RWE_ACT;
      DDRB_RD: r = RWE_RD;
      DDRB_WR: r = RWE_WR;
      DDRB_PRE: r = RWE_PRE;
      DDRB_REF: r = RWE_REF;
      DDRB_MRS: r = RWE_MRS;
      default: r = RWE_NOP;
    endcase
    return r;
  endfunction : ddrb_encode
endpackage : ddrb_pkg

/* File: verilog/ddrb_byte_lane.sv */
// One byte lane with its data strobe: write launch with centred strobe, read capture on the returned strobe.
// Assumes launch and mid pulses from the parent on the same core clock; pin inputs are asynchronous.
`timescale 1ns/1ps
module ddrb_byte_lane
  import ddrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic launch,
  input wire logic mid,
  input wire logic wr_take,
  input wire logic [LANE_W-1:0] wr_byte,
  input wire logic [LANE_W-1:0] dq_in,
  output logic [LANE_W-1:0] dq_out,
  output logic [LANE_W-1:0] dq_oe_n,
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe_n,
  output logic [LANE_W-1:0] rd_byte,
  output logic rd_strobe
);
  localparam int CW = $clog2(QUART_CYC + 1);
  localparam int CAP_DLY = QUART_CYC + 1;
  logic drive_q, drive_d, dqs_q, dqs_d;
  logic [LANE_W-1:0] dq_q, dq_d, rd_q, rd_d, dq_s1_q, dq_s2_q;
  logic dqs_s1_q, dqs_s2_q, dqs_s3_q, rdv_q, rdv_d;
  logic oe_n_q, oe_n_d;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    drive_d = drive_q;
    dq_d = dq_q;
    dqs_d = dqs_q;
    rd_d = rd_q;
    rdv_d = 1'b0;
    cnt_d = cnt_q;
    if (launch) begin
      drive_d = wr_take;
      if (wr_take) begin
        dq_d = wr_byte;
      end
      if (!wr_take) begin
        dqs_d = 1'b0;
      end
    end else if (mid && drive_q) begin
      dqs_d = ~dqs_q; // R9
    end
    if (!drive_q && (dqs_s2_q != dqs_s3_q)) begin
      cnt_d = CW'(QUART_CYC); // R10
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == CW'(1)) begin
        rd_d = dq_s2_q; // R10
        rdv_d = 1'b1;
      end
    end
    oe_n_d = ~drive_d;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drive_q <= 1'b0;
      dq_q <= '0;
      dqs_q <= 1'b0;
      rd_q <= '0;
      rdv_q <= 1'b0;
      cnt_q <= '0;
      oe_n_q <= 1'b1;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dqs_s1_q <= 1'b0;
      dqs_s2_q <= 1'b0;
      dqs_s3_q <= 1'b0;
    end else if (ce) begin
      drive_q <= drive_d;
      dq_q <= dq_d;
      dqs_q <= dqs_d;
      rd_q <= rd_d;
      rdv_q <= rdv_d;
      cnt_q <= cnt_d;
      oe_n_q <= oe_n_d;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      dqs_s1_q <= dqs_in;
      dqs_s2_q <= dqs_s1_q;
      dqs_s3_q <= dqs_s2_q;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_n = {LANE_W{oe_n_q}}; // R8
  assign dqs_out = dqs_q;
  assign dqs_oe_n = oe_n_q;
  assign rd_byte = rd_q;
  assign rd_strobe = rdv_q;

  a_strobe_centre: assert property (@(posedge core_clk) disable iff (!resetn)
    (drive_q && $changed(dqs_q)) |-> $past(mid)) else $error("Write strobe moved off the eye centre."); // R9
  a_read_delay: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
    (!drive_q && !$past(drive_q) && (dqs_s2_q != dqs_s3_q) && cnt_q == '0) |-> ##(CAP_DLY) rdv_q)
    else $error("Read capture not at the expected delay after the strobe edge."); // R10
endmodule : ddrb_byte_lane

/* File: verilog/ddrb_channel.sv */
// Top of the second DDR channel pin interface: forwarded clocks, row control, command coding and byte lanes.
// Assumes user-side inputs are on core_clk; memory pins feed the lanes through synchronisers.
`timescale 1ns/1ps
module ddrb_channel
  import ddrb_pkg::*;
#(
  parameter int INIT_CYC = INIT_CKE_LOW_CYC
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire ddrb_cmd_t cmd_code,
  input wire logic [1:0] cmd_row,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic [ADDR_W-1:0] cmd_addr,
  output logic cmd_ack,
  input wire logic suspend,
  input wire logic [NUM_ROWS-1:0] row_idle,
  output logic init_done,
  output logic in_self_refresh,
  input wire logic wr_beat_valid,
  input wire logic [DATA_W-1:0] wr_beat_data,
  input wire logic [CHK_W-1:0] wr_beat_check,
  output logic wr_beat_ack,
  output logic [DATA_W-1:0] rd_beat_data,
  output logic [CHK_W-1:0] rd_beat_check,
  output logic [LANES-1:0] rd_lane_valid,
  output logic [PAIRS_PER_DIMM*DIMMS-1:0] fwd_cmd_clock_p,
  output logic [PAIRS_PER_DIMM*DIMMS-1:0] fwd_cmd_clock_n,
  output logic [NUM_ROWS-1:0] row_select_n,
  output logic [NUM_ROWS-1:0] row_clock_enable,
  output logic [ADDR_W-1:0] mux_row_col_addr,
  output logic [BANK_W-1:0] bank_addr,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_cmd_n,
  input wire logic [DATA_W-1:0] mem_data_bus_in,
  output logic [DATA_W-1:0] mem_data_bus_out,
  output logic [DATA_W-1:0] mem_data_bus_oe_n,
  input wire logic [CHK_W-1:0] check_byte_bus_in,
  output logic [CHK_W-1:0] check_byte_bus_out,
  output logic [CHK_W-1:0] check_byte_bus_oe_n,
  input wire logic [LANES-1:0] byte_data_strobe_in,
  output logic [LANES-1:0] byte_data_strobe_out,
  output logic [LANES-1:0] byte_data_strobe_oe_n
);
  localparam int NPAIR = PAIRS_PER_DIMM * DIMMS;
  localparam int DIV_W = $clog2(HALF_CYC);
  localparam int INIT_W = $clog2(INIT_CYC + 1);

  logic [DIV_W-1:0] div_q, div_d;
  logic fclk_q, fclk_d, launch, rise, mid;
  logic [NPAIR-1:0] clkp_q, clkn_q;
  ddrb_state_t st_q, st_d;
  logic [INIT_W-1:0] init_q, init_d;
  logic [NUM_ROWS-1:0] cke_q, cke_d, cs_q, cs_d;
  logic [2:0] rwe_q, rwe_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [BANK_W-1:0] ba_q, ba_d;
  logic ack_q, ack_d, wr_take, wack_q;
  logic done_q, done_d, sref_q, sref_d;
  logic [LANES*LANE_W-1:0] lane_wr, lane_dq_in, lane_dq_out, lane_oe_n, lane_rd;

  // Forwarded clock divider; launch marks each clock edge, mid the centre of each half period.
  always_comb begin
    div_d = div_q + 1'b1;
    fclk_d = fclk_q;
    launch = 1'b0;
    rise = 1'b0;
    mid = (div_q == DIV_W'(QUART_CYC - 1));
    if (div_q == DIV_W'(HALF_CYC - 1)) begin
      div_d = '0;
      fclk_d = ~fclk_q; // R1
      launch = 1'b1;
      rise = ~fclk_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
      fclk_q <= 1'b0;
      clkp_q <= '0;
      clkn_q <= '1;
    end else if (ce) begin
      div_q <= div_d;
      fclk_q <= fclk_d;
      clkp_q <= {NPAIR{fclk_d}}; // R1 R3
      clkn_q <= {NPAIR{~fclk_d}}; // R2
    end
  end

  // Row control and command launch, updated on the forwarded clock rise; the init counter steps every core cycle.
  always_comb begin
    st_d = st_q;
    init_d = init_q;
    cke_d = cke_q;
    cs_d = cs_q;
    rwe_d = rwe_q;
    addr_d = addr_q;
    ba_d = ba_q;
    ack_d = 1'b0;
    if (st_q == ST_INIT && init_q != INIT_W'(INIT_CYC)) begin
      init_d = init_q + 1'b1;
    end
    if (rise) begin
      cs_d = CS_IDLE; // R4
      rwe_d = RWE_NOP;
      unique case (st_q)
        ST_INIT: begin
          if (init_q == INIT_W'(INIT_CYC)) begin
            cke_d = '1; // R12
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (suspend) begin
            cs_d = '0; // R13
            rwe_d = RWE_REF;
            cke_d = '0;
            st_d = ST_SREF;
          end else begin
            cke_d = ~row_idle; // R14 R15
            if (cmd_valid) begin
              cke_d[cmd_row] = 1'b1; // R14
              if (cke_q[cmd_row]) begin
                cs_d[cmd_row] = 1'b0; // R7
                rwe_d = ddrb_encode(cmd_code); // R17
                addr_d = cmd_addr; // R5
                ba_d = cmd_bank; // R6
                ack_d = 1'b1;
              end
            end
          end
        end
        ST_SREF: begin
          if (!suspend) begin
            cke_d = '1; // R13
            st_d = ST_RUN;
          end
        end
      endcase
    end
    done_d = (st_d != ST_INIT);
    sref_d = (st_d == ST_SREF);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_INIT;
      init_q <= '0;
      cke_q <= CKE_RST;
      cs_q <= CS_IDLE;
      rwe_q <= RWE_NOP;
      addr_q <= '0;
      ba_q <= '0;
      ack_q <= 1'b0;
      wack_q <= 1'b0;
      done_q <= 1'b0;
      sref_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      init_q <= init_d;
      cke_q <= cke_d;
      cs_q <= cs_d;
      rwe_q <= rwe_d;
      addr_q <= addr_d;
      ba_q <= ba_d;
      ack_q <= ack_d;
      wack_q <= wr_take;
      done_q <= done_d;
      sref_q <= sref_d;
    end
  end

  // Byte lanes: lanes zero to seven carry data bytes in ascending order, lane eight the check byte.
  assign wr_take = launch && wr_beat_valid && (st_q == ST_RUN);
  assign lane_wr = {wr_beat_check, wr_beat_data}; // R11 R16
  assign lane_dq_in = {check_byte_bus_in, mem_data_bus_in};

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    ddrb_byte_lane u_lane (
      .core_clk(core_clk),
      .resetn(resetn),
      .ce(ce),
      .launch(launch),
      .mid(mid),
      .wr_take(wr_take),
      .wr_byte(lane_wr[i*LANE_W +: LANE_W]),
      .dq_in(lane_dq_in[i*LANE_W +: LANE_W]),
      .dq_out(lane_dq_out[i*LANE_W +: LANE_W]),
      .dq_oe_n(lane_oe_n[i*LANE_W +: LANE_W]),
      .dqs_in(byte_data_strobe_in[i]),
      .dqs_out(byte_data_strobe_out[i]),
      .dqs_oe_n(byte_data_strobe_oe_n[i]),
      .rd_byte(lane_rd[i*LANE_W +: LANE_W]),
      .rd_strobe(rd_lane_valid[i])
    );
  end

  assign mem_data_bus_out = lane_dq_out[DATA_W-1:0]; // R8
  assign mem_data_bus_oe_n = lane_oe_n[DATA_W-1:0];
  assign check_byte_bus_out = lane_dq_out[LANES*LANE_W-1:DATA_W]; // R16
  assign check_byte_bus_oe_n = lane_oe_n[LANES*LANE_W-1:DATA_W];
  assign rd_beat_data = lane_rd[DATA_W-1:0]; // R11
  assign rd_beat_check = lane_rd[LANES*LANE_W-1:DATA_W];
  assign fwd_cmd_clock_p = clkp_q;
  assign fwd_cmd_clock_n = clkn_q;
  assign row_select_n = cs_q;
  assign row_clock_enable = cke_q;
  assign mux_row_col_addr = addr_q;
  assign bank_addr = ba_q;
  assign {row_strobe_n, col_strobe_n, write_cmd_n} = rwe_q;
  assign cmd_ack = ack_q;
  assign wr_beat_ack = wack_q;
  assign init_done = done_q;
  assign in_self_refresh = sref_q;

  a_clk_pair: assert property (@(posedge core_clk) disable iff (!resetn)
    fwd_cmd_clock_n == ~fwd_cmd_clock_p) else $error("Forwarded clock legs not complementary."); // R2
  a_clk_period: assert property (@(posedge core_clk) disable iff (!resetn || !ce)
    $rose(clkp_q[0]) |-> ##(2*HALF_CYC) $rose(clkp_q[0])) else $error("Forwarded clock period wrong."); // R1
  a_select_on_rise: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(cs_q) |-> $rose(clkp_q[0])) else $error("Row select changed off the clock rise."); // R4
  a_cke_on_rise: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(cke_q) |-> $rose(clkp_q[0])) else $error("Clock enable changed off the clock rise."); // R15
  a_addr_stable: assert property (@(posedge core_clk) disable iff (!resetn)
    !$rose(clkp_q[0]) |-> $stable(addr_q) && $stable(ba_q)) else $error("Address moved off the clock rise."); // R5
  a_cmd_coded: assert property (@(posedge core_clk) disable iff (!resetn)
    ack_q |-> $onehot(~cs_q) && rwe_q == ddrb_encode($past(cmd_code))) else $error("Command coded wrongly."); // R7
  a_init_cke: assert property (@(posedge core_clk) disable iff (!resetn)
    st_q == ST_INIT |-> cke_q == '0 && cs_q == CS_IDLE) else $error("Clock enable high during init."); // R12
  a_sref_cke: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(st_q == ST_SREF) |-> cke_q == '0 && cs_q == '0 && rwe_q == RWE_REF)
    else $error("Bad self-refresh entry."); // R13
  a_wake_first: assert property (@(posedge core_clk) disable iff (!resetn)
    ack_q |-> ($past(cke_q) & ~cs_q) == ~cs_q) else $error("Command sent to a powered-down row."); // R14
  a_wr_ack_run: assert property (@(posedge core_clk) disable iff (!resetn)
    wack_q |-> $past(launch) && $past(st_q) == ST_RUN) else $error("Write beat taken off its launch point."); // R8
  c_cmd_taken: cover property (@(posedge core_clk) disable iff (!resetn) ack_q);
  c_sref_exit: cover property (@(posedge core_clk) disable iff (!resetn) $fell(st_q == ST_SREF));
  c_write_beat: cover property (@(posedge core_clk) disable iff (!resetn) wack_q);
  c_read_byte: cover property (@(posedge core_clk) disable iff (!resetn) rd_lane_valid[0]);
endmodule : ddrb_channel

/* File: tb/ddrb_mem_model.sv */
// Memory model for the second channel: samples commands, captures written bytes, returns read bursts.
// Assumes the controller's pin outputs; it resolves the shared data and strobe wires.
`timescale 1ns/1ps
module ddrb_mem_model
  import ddrb_pkg::*;
(
  input wire logic [5:0] clk_p,
  input wire logic [5:0] clk_n,
  input wire logic [3:0] row_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_cmd_n,
  input wire logic [1:0] bank_addr,
  input wire logic [12:0] mux_row_col_addr,
  input wire logic [71:0] dq_out,
  input wire logic [71:0] dq_oe_n,
  input wire logic [8:0] dqs_out,
  input wire logic [8:0] dqs_oe_n,
  output wire logic [71:0] dq_in,
  output wire logic [8:0] dqs_in
);
  logic [71:0] drv_q = '0;
  logic [8:0] dqs_q = '0;
  logic [71:0] cap_r;
  logic [71:0] cap_f;
  logic [21:0] held;
  logic [21:0] cmd_seen;
  assign dq_in = (~dq_oe_n & dq_out) | (dq_oe_n & drv_q);
  assign dqs_in = (~dqs_oe_n & dqs_out) | (dqs_oe_n & dqs_q);
  always @(negedge clk_p[0]) begin
    held <= {row_select_n, row_strobe_n, col_strobe_n, write_cmd_n, bank_addr, mux_row_col_addr};
  end
  // The command latched at the true leg's fall is taken where the true leg rises and the complement leg falls.
  always @(posedge clk_p[0]) begin
    #1;
    if (clk_n[0] === 1'b0) cmd_seen <= held;
  end
  for (genvar i = 0; i < 9; i++) begin : g_lane
    always @(posedge dqs_out[i]) begin
      if (!dqs_oe_n[i]) cap_r[8*i+:8] <= dq_out[8*i+:8];
    end
    always @(negedge dqs_out[i]) begin
      if (!dqs_oe_n[i]) cap_f[8*i+:8] <= dq_out[8*i+:8];
    end
  end
  // Two read beats with edge-aligned strobes; then the data lines show the inverse and the strobe rests low.
  task automatic read_burst(input logic [71:0] a, input logic [71:0] b);
    dqs_q = '0;
    #160;
    drv_q = a;
    dqs_q = '1;
    #80;
    drv_q = b;
    dqs_q = '0;
    #80;
    drv_q = ~b;
  endtask : read_burst
endmodule : ddrb_mem_model

/* File: tb/tb_top.sv */
// Self-checking bench for the second DDR channel pin interface.
// Assumes the memory model beside it and a shortened initialisation count.
`timescale 1ns/1ps
module tb_top;
  import ddrb_pkg::*;
  typedef struct {ddrb_cmd_t code; logic [1:0] row; logic [1:0] bank; logic [12:0] addr; logic [2:0] rwe;} ddrb_row_t;
  logic core_clk, resetn, ce, cmd_valid, suspend, wr_beat_valid;
  ddrb_cmd_t cmd_code;
  logic [1:0] cmd_row, cmd_bank;
  logic [12:0] cmd_addr;
  logic [3:0] row_idle;
  logic [63:0] wr_beat_data;
  logic [7:0] wr_beat_check;
  wire logic cmd_ack, init_done, in_self_refresh, wr_beat_ack, rs_n, cs_n, we_n;
  wire logic [63:0] rd_beat_data, dq_in, dq_out, dq_oe_n;
  wire logic [7:0] rd_beat_check, ck_in, ck_out, ck_oe_n;
  wire logic [8:0] rd_lane_valid, dqs_in, dqs_out, dqs_oe_n;
  wire logic [5:0] clk_p, clk_n;
  wire logic [3:0] sel_n, cke;
  wire logic [12:0] ma;
  wire logic [1:0] ba;
  int failures = 0;
  int tests_run = 0;
  ddrb_row_t rows [7] = '{'{DDRB_PRE, 2'h0, 2'h0, 13'h0400, 3'h2}, '{DDRB_MRS, 2'h1, 2'h0, 13'h0062, 3'h0},
    '{DDRB_REF, 2'h2, 2'h3, 13'h0000, 3'h1}, '{DDRB_ACT, 2'h3, 2'h2, 13'h1FFF, 3'h3},
    '{DDRB_RD, 2'h3, 2'h2, 13'h0155, 3'h5}, '{DDRB_WR, 2'h0, 2'h1, 13'h0AAA, 3'h4},
    '{DDRB_NOP, 2'h1, 2'h3, 13'h0001, 3'h7}};

  ddrb_channel #(.INIT_CYC(20)) u_ddrb_channel (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_row(cmd_row), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .cmd_ack(cmd_ack), .suspend(suspend), .row_idle(row_idle), .init_done(init_done),
    .in_self_refresh(in_self_refresh), .wr_beat_valid(wr_beat_valid), .wr_beat_data(wr_beat_data),
    .wr_beat_check(wr_beat_check), .wr_beat_ack(wr_beat_ack), .rd_beat_data(rd_beat_data),
    .rd_beat_check(rd_beat_check), .rd_lane_valid(rd_lane_valid), .fwd_cmd_clock_p(clk_p), .fwd_cmd_clock_n(clk_n),
    .row_select_n(sel_n), .row_clock_enable(cke), .mux_row_col_addr(ma), .bank_addr(ba), .row_strobe_n(rs_n),
    .col_strobe_n(cs_n), .write_cmd_n(we_n), .mem_data_bus_in(dq_in), .mem_data_bus_out(dq_out),
    .mem_data_bus_oe_n(dq_oe_n), .check_byte_bus_in(ck_in), .check_byte_bus_out(ck_out),
    .check_byte_bus_oe_n(ck_oe_n), .byte_data_strobe_in(dqs_in), .byte_data_strobe_out(dqs_out),
    .byte_data_strobe_oe_n(dqs_oe_n));

  ddrb_mem_model u_ddrb_mem_model (.clk_p(clk_p), .clk_n(clk_n), .row_select_n(sel_n), .row_strobe_n(rs_n),
    .col_strobe_n(cs_n), .write_cmd_n(we_n), .bank_addr(ba), .mux_row_col_addr(ma), .dq_out({ck_out, dq_out}),
    .dq_oe_n({ck_oe_n, dq_oe_n}), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .dq_in({ck_in, dq_in}), .dqs_in(dqs_in));

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Holds a command until it is acknowledged, then drops it.
  task automatic issue(input ddrb_cmd_t c, input logic [1:0] r, input logic [1:0] b, input logic [12:0] a);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_row = r;
    cmd_bank = b;
    cmd_addr = a;
    @(negedge core_clk);
    for (int k = 0; k < 60 && cmd_ack !== 1'b1; k++) @(negedge core_clk);
    chk(cmd_ack, 1'b1);
    cmd_valid = 1'b0;
  endtask : issue

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    failures++;
    summarize();
  end

  initial begin
    logic [21:0] e;
    logic [5:0] ph;
    resetn = 0; ce = 1; cmd_valid = 0; cmd_code = DDRB_NOP; cmd_row = 0; cmd_bank = 0; cmd_addr = 0;
    suspend = 0; row_idle = 0; wr_beat_valid = 0; wr_beat_data = 0; wr_beat_check = 0;
    repeat (8) @(negedge core_clk);
    chk({sel_n, cke, rs_n, cs_n, we_n, clk_p, clk_n}, {4'hF, 4'h0, 3'h7, 6'h00, 6'h3F});
    chk({dqs_oe_n, ck_oe_n}, {17{1'b1}});
    chk(dq_oe_n, {64{1'b1}});
    resetn = 1;
    for (int k = 0; k < 200 && init_done !== 1'b1; k++) @(negedge core_clk);
    chk({init_done, cke}, {1'b1, 4'hF});
    foreach (rows[i]) begin
      e = {~(4'h1 << rows[i].row), rows[i].rwe, rows[i].bank, rows[i].addr};
      issue(rows[i].code, rows[i].row, rows[i].bank, rows[i].addr);
      chk({sel_n, rs_n, cs_n, we_n, ba, ma}, e);
      chk({clk_p ^ clk_n, clk_p ^ {6{clk_p[0]}}}, {6'h3F, 6'h00});
      repeat (17) @(negedge core_clk);
      chk(u_ddrb_mem_model.cmd_seen, e);
      chk({sel_n, rs_n, cs_n, we_n}, {4'hF, 3'h7});
    end
    wr_beat_valid = 1; wr_beat_data = 64'h8877665544332211; wr_beat_check = 8'hA9;
    for (int k = 0; k < 20 && wr_beat_ack !== 1'b1; k++) @(negedge core_clk);
    chk(wr_beat_ack, 1'b1);
    wr_beat_data = 64'hF0E1D2C3B4A59687; wr_beat_check = 8'hB9;
    @(negedge core_clk);
    for (int k = 0; k < 20 && wr_beat_ack !== 1'b1; k++) @(negedge core_clk);
    chk(wr_beat_ack, 1'b1);
    wr_beat_valid = 0;
    repeat (24) @(negedge core_clk);
    chk(u_ddrb_mem_model.cap_r, {8'hA9, 64'h8877665544332211});
    chk(u_ddrb_mem_model.cap_f, {8'hB9, 64'hF0E1D2C3B4A59687});
    fork
      u_ddrb_mem_model.read_burst({8'h5A, 64'h0807060504030201}, {8'hC3, 64'h7F6E5D4C3B2A1908});
    join_none
    for (int k = 0; k < 60 && rd_lane_valid[8] !== 1'b1; k++) @(negedge core_clk);
    chk(rd_lane_valid, 9'h1FF);
    repeat (2) @(negedge core_clk);
    chk({rd_beat_check, rd_beat_data}, {8'h5A, 64'h0807060504030201});
    for (int k = 0; k < 20 && rd_lane_valid[8] !== 1'b1; k++) @(negedge core_clk);
    chk(rd_lane_valid, 9'h1FF);
    repeat (2) @(negedge core_clk);
    chk({rd_beat_check, rd_beat_data}, {8'hC3, 64'h7F6E5D4C3B2A1908});
    row_idle = 4'h5;
    repeat (40) @(negedge core_clk);
    chk(cke, 4'hA);
    issue(DDRB_ACT, 2'h0, 2'h1, 13'h0123);
    chk({cke[0], sel_n, rs_n, cs_n, we_n}, {1'b1, 4'hE, 3'h3});
    row_idle = 4'h0;
    suspend = 1;
    for (int k = 0; k < 40 && in_self_refresh !== 1'b1; k++) @(negedge core_clk);
    chk({in_self_refresh, cke, sel_n, rs_n, cs_n, we_n}, {1'b1, 4'h0, 4'h0, 3'h1});
    suspend = 0;
    for (int k = 0; k < 40 && in_self_refresh !== 1'b0; k++) @(negedge core_clk);
    chk({in_self_refresh, cke}, {1'b0, 4'hF});
    ce = 0;
    ph = clk_p;
    repeat (20) @(negedge core_clk);
    chk({clk_p, sel_n, cke, rs_n, cs_n, we_n}, {ph, 4'hF, 4'hF, 3'h7});
    ce = 1;
    resetn = 0;
    @(negedge core_clk);
    chk({init_done, in_self_refresh, sel_n, cke, rs_n, cs_n, we_n, clk_p, clk_n},
      {2'b00, 4'hF, 4'h0, 3'h7, 6'h00, 6'h3F});
    resetn = 1;
    repeat (2) @(negedge core_clk);
    chk({init_done, cke, sel_n}, {1'b0, 4'h0, 4'hF});
    for (int k = 0; k < 200 && init_done !== 1'b1; k++) @(negedge core_clk);
    chk({init_done, cke}, {1'b1, 4'hF});
    issue(DDRB_RD, 2'h2, 2'h1, 13'h0040);
    chk({sel_n, rs_n, cs_n, we_n, ba, ma}, {4'hB, 3'h5, 2'h1, 13'h0040});
    summarize();
  end
endmodule : tb_top
